// >>> hdl/asb_regs.svh
// register offsets, field positions, reset values and cycle counts
// Function
// - selection lives in a software shadow register
// - idle: shadow copied every converter cycle
// - running conversion freezes the applied selection
// - copying resumes in final conversion cycle
// - conversion begins at next converter clock edge
// - boundary scan overrides upper four analog pins
// - continuous mode: auto-started conversion uses the selection copied in the final cycle
// - halt in quiet sleep starts a conversion
// - completion interrupt wakes core, request raised only with interrupt enable set
// - other sleep modes never clear converter enable
// - over-range input reads near full scale
// - start bit reads one until completion
// - result and done flag update together
// - selection has no effect until enabled
`ifndef ASB_REGS_SVH
`define ASB_REGS_SVH
`define ASB_OFF_SEL 2'h0
`define ASB_OFF_CTRL 2'h1
`define ASB_OFF_RES_LO 2'h2
`define ASB_OFF_RES_HI 2'h3
`define ASB_BIT_EN 7
`define ASB_BIT_START 6
`define ASB_BIT_FREE 5
`define ASB_BIT_DONE 4
`define ASB_BIT_IE 3
`define ASB_SEL_REF_HI 7
`define ASB_SEL_REF_LO 6
`define ASB_SEL_CHAN_HI 4
`define ASB_SEL_CHAN_LO 0
`define ASB_SEL_RST 7'h00
`define ASB_CYC_NORMAL 5'h0D
`define ASB_CYC_FIRST 5'h19
`define ASB_PRESC_DIV 8'h04
`endif

// >>> hdl/asb_pkg.sv
// types shared by the converter control modules
package asb_pkg;
  typedef struct packed {
    logic [1:0] refsel;
    logic [4:0] chan;
  } asb_sel_t;
  typedef enum logic [1:0] {ASB_IDLE, ASB_ARMED, ASB_CONV} asb_state_t;
  typedef struct packed {
    asb_state_t state;
    logic [4:0] cnt;
    logic first;
    logic start;
    logic free;
    logic ie;
    logic done;
    logic en;
    logic [9:0] result;
    logic halt_prev;
    logic [7:0] rdata;
    logic [7:0] pin_en;
  } asb_top_st_t;
  typedef struct packed {
    asb_sel_t shadow;
    asb_sel_t applied;
  } asb_shd_st_t;
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } asb_tick_st_t;
endpackage

// >>> hdl/asb_sel_if.sv
// carrier between control, prescaler and selection shadow
interface asb_sel_if;
  import asb_pkg::*;
  logic en;
  logic tick;
  logic lock;
  logic wr;
  asb_sel_t wdata;
  asb_sel_t shadow;
  asb_sel_t applied;
  modport ctl (output en, output lock, output wr, output wdata,
    input tick, input shadow, input applied);
  modport tck (input en, output tick);
  modport shd (input tick, input lock, input wr, input wdata,
    output shadow, output applied);
endinterface

// >>> hdl/asb_tick.sv
// prescaler making the one-cycle converter clock tick
`include "asb_regs.svh"
module asb_tick #(
  parameter logic [7:0] DIV = `ASB_PRESC_DIV
) (
  input wire logic core_clk,
  input wire logic rst_n,
  asb_sel_if.tck sel
);
  import asb_pkg::*;
  asb_tick_st_t q;
  asb_tick_st_t d;
  // held in reset while the converter is off
  always_comb
  begin
    d = q;
    d.tick = 1'h0;
    if (!sel.en)
    begin
      d.cnt = 8'h00;
    end
    else if (q.cnt == DIV - 8'h01)
    begin
      d.cnt = 8'h00;
      d.tick = 1'h1;
    end
    else
    begin
      d.cnt = q.cnt + 8'h01;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end
  assign sel.tick = q.tick && sel.en;
endmodule

// >>> hdl/asb_shadow.sv
// shadow and applied channel and reference selection
module asb_shadow (
  input wire logic core_clk,
  input wire logic rst_n,
  asb_sel_if.shd sel
);
  import asb_pkg::*;
  asb_shd_st_t q;
  asb_shd_st_t d;
  always_comb
  begin
    d = q;
    if (sel.wr)
      d.shadow = sel.wdata;
    if (sel.tick && !sel.lock)
      d.applied = q.shadow;
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end
  assign sel.shadow = q.shadow;
  assign sel.applied = q.applied;
  property p_frozen;
    @(posedge core_clk) disable iff (!rst_n)
      sel.lock |=> $stable(q.applied);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("applied selection moved while locked");
  property p_copy;
    @(posedge core_clk) disable iff (!rst_n)
      sel.tick && !sel.lock |=> q.applied == $past(q.shadow);
  endproperty
  a_copy: assert property (p_copy)
    else $error("shadow not copied on unlocked tick");
  property p_readback;
    @(posedge core_clk) disable iff (!rst_n)
      sel.wr |=> q.shadow == $past(sel.wdata);
  endproperty
  a_readback: assert property (p_readback)
    else $error("shadow does not hold written value");
endmodule

// >>> hdl/asb_top.sv
// converter selection shadow, sequencing and sleep-start control
`include "asb_regs.svh"
module asb_top #(
  parameter logic [7:0] PRESC_DIV = `ASB_PRESC_DIV
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic core_halted,
  input wire logic sleep_quiet_mode,
  input wire logic jtag_enable,
  input wire logic [9:0] sar_code,
  output logic conv_irq,
  output logic conv_busy,
  output logic converter_on,
  output logic sample_start,
  output logic [1:0] applied_reference,
  output logic [4:0] applied_channel,
  output logic [7:0] analog_pin_en
);
  import asb_pkg::*;

  asb_sel_if sel ();
  asb_top_st_t q;
  asb_top_st_t d;
  logic [4:0] conv_len;
  logic last_cyc;
  logic ctrl_wr;
  logic sleep_trig;

  // ****************************************
  // prescaler and selection shadow
  // ****************************************
  asb_tick #(
    .DIV(PRESC_DIV)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sel(sel.tck)
  );

  asb_shadow u_shadow (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sel(sel.shd)
  );

  // ****************************************
  // sequencing helpers
  // ****************************************
  assign conv_len = q.first ? `ASB_CYC_FIRST : `ASB_CYC_NORMAL;
  assign last_cyc = (q.state == ASB_CONV) && (q.cnt == conv_len - 5'h01);
  assign ctrl_wr = reg_wr && (reg_addr == `ASB_OFF_CTRL);
  // halt edge while in quiet (noise-reduction) sleep only
  assign sleep_trig = core_halted && !q.halt_prev && sleep_quiet_mode &&
    q.en && (q.state == ASB_IDLE) && !q.start;

  assign sel.en = q.en;
  // locked from conversion start up to its final cycle
  assign sel.lock = (q.state == ASB_CONV) && !last_cyc;
  assign sel.wr = reg_wr && (reg_addr == `ASB_OFF_SEL);
  assign sel.wdata = '{
    refsel: reg_wdata[`ASB_SEL_REF_HI:`ASB_SEL_REF_LO],
    chan: reg_wdata[`ASB_SEL_CHAN_HI:`ASB_SEL_CHAN_LO]
  };

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    d = q;
    d.rdata = 8'h00;
    d.halt_prev = core_halted;
    // register reads
    if (reg_rd)
    begin
      unique case (reg_addr)
        `ASB_OFF_SEL:
        begin
          d.rdata = {sel.shadow.refsel, 1'h0, sel.shadow.chan};
        end
        `ASB_OFF_CTRL:
        begin
          d.rdata[`ASB_BIT_EN] = q.en;
          d.rdata[`ASB_BIT_START] = q.start;
          d.rdata[`ASB_BIT_FREE] = q.free;
          d.rdata[`ASB_BIT_DONE] = q.done;
          d.rdata[`ASB_BIT_IE] = q.ie;
        end
        `ASB_OFF_RES_LO:
        begin
          d.rdata = q.result[7:0];
        end
        `ASB_OFF_RES_HI:
        begin
          d.rdata = {6'h00, q.result[9:8]};
        end
      endcase
    end
    // control writes; enable changes only here
    if (ctrl_wr)
    begin
      d.en = reg_wdata[`ASB_BIT_EN];
      d.free = reg_wdata[`ASB_BIT_FREE];
      d.ie = reg_wdata[`ASB_BIT_IE];
      if (reg_wdata[`ASB_BIT_DONE])
        d.done = 1'h0;
      if (reg_wdata[`ASB_BIT_START] && reg_wdata[`ASB_BIT_EN] &&
        q.en && (q.state == ASB_IDLE))
      begin
        d.start = 1'h1;
        d.state = ASB_ARMED;
      end
    end
    // automatic start once the core halts in quiet sleep
    if (sleep_trig)
    begin
      d.start = 1'h1;
      d.state = ASB_ARMED;
    end
    unique case (q.state)
      ASB_IDLE:
      begin
        d.cnt = 5'h00;
      end
      ASB_ARMED:
      begin
        if (sel.tick)
        begin
          d.state = ASB_CONV;
          d.cnt = 5'h00;
        end
      end
      ASB_CONV:
      begin
        if (sel.tick)
        begin
          if (last_cyc)
          begin
            // over-range codes pass as the converter gives them
            d.result = sar_code;
            d.done = 1'h1;
            d.first = 1'h0;
            d.cnt = 5'h00;
            if (!q.free)
            begin
              d.start = 1'h0;
              d.state = ASB_IDLE;
            end
            else
            begin
              d.state = ASB_CONV;
            end
          end
          else
          begin
            d.cnt = q.cnt + 5'h01;
          end
        end
      end
    endcase
    // turning off aborts and forces a long first conversion
    if (!d.en)
    begin
      d.state = ASB_IDLE;
      d.start = 1'h0;
      d.first = 1'h1;
      d.cnt = 5'h00;
    end
    // converter pins: applied channel only while enabled
    d.pin_en = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (q.en && (sel.applied.chan == i[4:0]))
        d.pin_en[i] = 1'h1;
      if (jtag_enable && (i >= 4))
        d.pin_en[i] = 1'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.state <= ASB_IDLE;
      q.first <= 1'h1;
    end
    else
    begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = q.rdata;
  // request stays until software clears the flag
  assign conv_irq = q.done && q.ie;
  assign conv_busy = q.start;
  assign converter_on = q.en;
  assign sample_start = (q.state == ASB_CONV) && (q.cnt == 5'h00);
  assign applied_reference = q.en ? sel.applied.refsel : 2'h0;
  assign applied_channel = q.en ? sel.applied.chan : 5'h00;
  assign analog_pin_en = q.pin_en;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_last_tick;
    last_cyc && sel.tick && q.en && !ctrl_wr;
  endsequence

  sequence s_armed_tick;
    (q.state == ASB_ARMED) && sel.tick && q.en && !ctrl_wr;
  endsequence

  property p_start_edge;
    s_armed_tick |=> (q.state == ASB_CONV) && (q.cnt == 5'h00);
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("conversion did not begin on converter tick");

  property p_done_result;
    s_last_tick |=> q.done && (q.result == $past(sar_code));
  endproperty
  a_done_result: assert property (p_done_result)
    else $error("result and done flag not updated together");

  property p_start_reads;
    (q.state != ASB_IDLE) |-> q.start;
  endproperty
  a_start_reads: assert property (p_start_reads)
    else $error("start bit low during conversion");

  property p_start_clear;
    s_last_tick ##0 !q.free |=> !q.start && (q.state == ASB_IDLE);
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("start bit not cleared on completion");

  property p_free_restart;
    s_last_tick ##0 q.free |=> (q.state == ASB_CONV) && sel.lock;
  endproperty
  a_free_restart: assert property (p_free_restart)
    else $error("continuous conversion did not restart locked");

  property p_sleep_start;
    sleep_trig && !ctrl_wr |=> (q.state == ASB_ARMED) ##[1:300]
      (q.state == ASB_CONV);
  endproperty
  a_sleep_start: assert property (p_sleep_start)
    else $error("sleep halt did not start a conversion");

  property p_irq;
    s_last_tick ##0 q.ie |=> conv_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("completion request missing");

  property p_jtag;
    $past(jtag_enable) |-> (analog_pin_en[7:4] == 4'h0);
  endproperty
  a_jtag: assert property (p_jtag)
    else $error("scan enable did not override upper pins");

  property p_en_kept;
    !ctrl_wr |=> (q.en == $past(q.en));
  endproperty
  a_en_kept: assert property (p_en_kept)
    else $error("enable changed without a control write");

  property p_off_quiet;
    !q.en |-> !sel.tick && (applied_channel == 5'h00) && !conv_busy;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("selection active while converter off");

  property p_len;
    (q.state == ASB_CONV) |-> (q.cnt <= conv_len - 5'h01);
  endproperty
  a_len: assert property (p_len)
    else $error("conversion counter past its length");

  property p_sample_flag;
    s_armed_tick |=> sample_start;
  endproperty
  a_sample_flag: assert property (p_sample_flag)
    else $error("sample start missing at conversion start");

  property p_free_sample;
    s_last_tick ##0 q.free |=> sample_start && conv_busy;
  endproperty
  a_free_sample: assert property (p_free_sample)
    else $error("continuous conversion did not sample again");

  property p_done_hold;
    q.done && !(ctrl_wr && reg_wdata[`ASB_BIT_DONE]) |=> q.done;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("completion request dropped without a clear");

  property p_busy_refused;
    ctrl_wr && reg_wdata[`ASB_BIT_EN] && reg_wdata[`ASB_BIT_START] &&
      (q.state == ASB_CONV) && !last_cyc && (q.cnt != 5'h00) |=>
      (q.cnt != 5'h00);
  endproperty
  a_busy_refused: assert property (p_busy_refused)
    else $error("start while busy restarted the conversion");

  property p_sel_read;
    sel.wr ##1 !sel.wr ##1 (reg_rd && (reg_addr == `ASB_OFF_SEL) && !sel.wr)
      |=> (reg_rdata == ($past(reg_wdata, 3) & 8'hDF));
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("selection read differs from last write");

  property p_pins_off;
    !q.en |=> (analog_pin_en == 8'h00);
  endproperty
  a_pins_off: assert property (p_pins_off)
    else $error("analog pin enabled while converter off");

  property p_frozen_out;
    sel.lock && !ctrl_wr |=>
      $stable(applied_channel) && $stable(applied_reference);
  endproperty
  a_frozen_out: assert property (p_frozen_out)
    else $error("applied selection output moved during conversion");

  property p_sleep_busy;
    sleep_trig && !ctrl_wr |=> conv_busy;
  endproperty
  a_sleep_busy: assert property (p_sleep_busy)
    else $error("sleep halt did not raise the busy bit");
endmodule

// >>> verif/tb_asb_top.sv
// self-checking bench for the converter selection control
module tb_asb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, reg_wr, reg_rd, core_halted;
  logic sleep_quiet_mode, jtag_enable;
  logic conv_irq, conv_busy, converter_on, sample_start;
  logic [1:0] reg_addr, applied_reference;
  logic [4:0] applied_channel;
  logic [7:0] reg_wdata, reg_rdata, analog_pin_en, d;
  logic [9:0] sar_code;
  int err_total, n_tests, n;

  asb_top #(.PRESC_DIV(8'h01)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_halted(core_halted),
    .sleep_quiet_mode(sleep_quiet_mode), .jtag_enable(jtag_enable),
    .sar_code(sar_code), .conv_irq(conv_irq), .conv_busy(conv_busy),
    .converter_on(converter_on), .sample_start(sample_start),
    .applied_reference(applied_reference),
    .applied_channel(applied_channel), .analog_pin_en(analog_pin_en));

  // ****************************************
  // clock
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [9:0] seen,
    input logic [9:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // sel 0 busy, 1 irq, 2 sample start
  task automatic wait_on(input int sel, input logic lvl, input int lim);
    logic v;
    n = 0;
    v = ~lvl;
    while (v !== lvl && n < lim)
    begin
      @(posedge core_clk);
      #1;
      n++;
      v = (sel == 0) ? conv_busy : (sel == 1) ? conv_irq : sample_start;
    end
    if (v !== lvl)
    begin
      err_total++;
      $display("unexpected timeout: signal %0d after %0d cycles", sel, n);
      tally_and_finish();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_shadow;
    chk("on_at_reset", converter_on, 1'b0);
    wr(2'h0, 8'hFF);
    rd(2'h0, d);
    chk("sel_read", d, 8'hDF);
    repeat (3) @(posedge core_clk);
    #1;
    chk("chan_off", applied_channel, 5'h00);
    chk("ref_off", applied_reference, 2'h0);
  endtask

  task automatic t_enable;
    wr(2'h1, 8'h80);
    wr(2'h0, 8'h45);
    repeat (3) @(posedge core_clk);
    #1;
    chk("on", converter_on, 1'b1);
    chk("chan_idle", applied_channel, 5'h05);
    chk("ref_idle", applied_reference, 2'h1);
  endtask

  task automatic t_single;
    wr(2'h1, 8'hC0);
    chk("busy", conv_busy, 1'b1);
    wait_on(2, 1'b1, 4);
    repeat (2) @(posedge core_clk);
    wr(2'h0, 8'h83);
    chk("chan_frozen", applied_channel, 5'h05);
    rd(2'h0, d);
    chk("sel_new", d, 8'h83);
    wait_on(0, 1'b0, 40);
    chk("chan_after", applied_channel, 5'h03);
    chk("ref_after", applied_reference, 2'h2);
    rd(2'h1, d);
    chk("done", d[4], 1'b1);
    rd(2'h2, d);
    chk("res_lo", d, 8'hA5);
    rd(2'h3, d);
    chk("res_hi", d, 8'h03);
    wr(2'h1, 8'hD0);
    wait_on(0, 1'b0, 30);
    chk("normal_len", n[9:0], 10'h00E);
  endtask

  task automatic t_cont;
    wr(2'h0, 8'h41);
    wr(2'h1, 8'hF8);
    wait_on(1, 1'b1, 40);
    wr(2'h0, 8'h42);
    repeat (3) @(posedge core_clk);
    #1;
    chk("chan_auto", applied_channel, 5'h01);
    chk("busy_cont", conv_busy, 1'b1);
    wr(2'h1, 8'hD8);
    wait_on(1, 1'b1, 40);
    repeat (2) @(posedge core_clk);
    #1;
    chk("chan_next", applied_channel, 5'h02);
    chk("busy_end", conv_busy, 1'b0);
  endtask

  task automatic t_sleep;
    wr(2'h1, 8'h98);
    @(posedge core_clk);
    sleep_quiet_mode <= 1'b1;
    core_halted <= 1'b1;
    wait_on(0, 1'b1, 4);
    @(posedge core_clk);
    core_halted <= 1'b0;
    wait_on(1, 1'b1, 40);
    chk("irq", conv_irq, 1'b1);
    wr(2'h1, 8'h98);
    @(posedge core_clk);
    sleep_quiet_mode <= 1'b0;
    core_halted <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk("no_start", conv_busy, 1'b0);
    chk("stays_on", converter_on, 1'b1);
    @(posedge core_clk);
    core_halted <= 1'b0;
    wr(2'h1, 8'h00);
    wr(2'h1, 8'h80);
  endtask

  task automatic t_scan;
    wr(2'h0, 8'h06);
    repeat (3) @(posedge core_clk);
    #1;
    chk("pin6", analog_pin_en, 8'h40);
    @(posedge core_clk);
    jtag_enable <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("pin6_scan", analog_pin_en, 8'h00);
    wr(2'h0, 8'h02);
    repeat (3) @(posedge core_clk);
    #1;
    chk("pin2_scan", analog_pin_en, 8'h04);
    @(posedge core_clk);
    jtag_enable <= 1'b0;
    wr(2'h1, 8'h00);
    repeat (3) @(posedge core_clk);
    #1;
    chk("chan_disabled", applied_channel, 5'h00);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    err_total = 0;
    n_tests = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    core_halted = 1'b0;
    sleep_quiet_mode = 1'b0;
    jtag_enable = 1'b0;
    sar_code = 10'h3A5;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_shadow();
    t_enable();
    t_single();
    t_cont();
    t_sleep();
    t_scan();
    tally_and_finish();
  end
endmodule
